// >>> rtl/rsc_serial.sv
// Summary of operation
// - Last command bit taken on eighth rise
// - Read drive starts at eighth falling edge
// - Output bits change on falling edges
// - Data pin released at following rising edge
// - Read bytes go out LSB first
// - Extra clocks keep bursting data while selected
// - Seconds bit 7 is active-low clock enable
// - Enable low drives output, high floats it
// - Enabled output carries crystal square wave
// - Reset leaves crystal output enabled
// - Reset returns all state to defaults
// - Select frames transfers; pin floats when low
// - First eight bits are the command byte
// - Input bits sampled on rises, LSB first
`timescale 1ns/1ns
`default_nettype none
`include "rsc_cfg.svh"

module rsc_serial
  import rsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial link pins
  input wire logic cs_i,
  input wire logic sclk_i,
  input wire logic io_i,
  output logic io_o,
  output logic io_oe_n_o,
  // Crystal oscillator and its buffered output pin
  input wire logic xtal_i,
  output logic crystal_clock_output_o,
  output logic crystal_clock_output_oe_n_o,
  // Read data supplied by the register side
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  input wire logic [7:0] rd_data_i,
  // Decoded command and received write bytes
  output logic cmd_valid_o,
  output rsc_cmd_t cmd_o,
  output logic wr_valid_o,
  output rsc_wr_t wr_o
);

  // Limits of this port:
  // - every pin level must last one system clock to be sure of being seen;
  // - read data reaches the pin about three system clocks after the
  //   host's falling edge, so the host must keep the clock low longer;
  // - write bytes are handed on as they arrive, and only the first byte
  //   after the seconds write command moves the clock output enable;
  // - factory test codes are not screened; avoiding them is the host's duty.

  rsc_state_t s_r, s_nxt;
  logic sclk_rise, sclk_fall, cs_on;
  logic [7:0] in_byte;
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_data;
  logic rd_fall, byte_start, byte_done, sec_first;
  logic [7:0] next_byte;
  logic next_bit;

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  // Drained only on serial clock edges, so a slow host lets it fill
  // and rd_ready_o then stalls the register side.
  rsc_fifo #(
    .W(`RSC_FIFO_WIDTH),
    .D(`RSC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(rd_valid_i),
    .in_ready_o(rd_ready_o),
    .in_data_i(rd_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  assign cs_on = s_r.cs_s[1];
  assign sclk_rise = s_r.sclk_s[1] && !s_r.sclk_d;
  assign sclk_fall = !s_r.sclk_s[1] && s_r.sclk_d;
  assign in_byte = {s_r.io_s[1], s_r.sh[7:1]};

  // ----------------------------------------------------------------
  // Transfer events
  // ----------------------------------------------------------------
  // Each event rests on one detected pin edge, so a pin level shorter
  // than one system clock can be lost as a whole rather than half taken.
  // The bit counter wraps on its own, which is what keeps a burst going.
  assign rd_fall = cs_on && (s_r.phase == PH_RD) && sclk_fall;
  assign byte_start = (s_r.bit_cnt == 3'h0);
  assign byte_done = sclk_rise && (s_r.bit_cnt == `RSC_LAST_BIT);
  assign sec_first = s_r.first_wr && (s_r.cmd == `RSC_SEC_WR_CMD);
  assign fifo_pop = rd_fall && byte_start && fifo_valid;

  // ----------------------------------------------------------------
  // Read bit selection
  // ----------------------------------------------------------------
  // An empty buffer sends the filler byte instead of stalling: the
  // host clocks at its own pace and cannot wait for the device, so a
  // late register side shows up as filler, not as a shifted stream.
  assign next_byte = fifo_valid ? fifo_data : `RSC_UNDERRUN_BYTE;
  assign next_bit = byte_start ? next_byte[0] : s_r.obyte[s_r.bit_cnt];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Every pin passes two flops before any decision reads it; the edge
    // detector compares the second flop with its own delayed copy.
    s_nxt.cs_s = {s_r.cs_s[0], cs_i};
    s_nxt.sclk_s = {s_r.sclk_s[0], sclk_i};
    s_nxt.io_s = {s_r.io_s[0], io_i};
    s_nxt.xtal_s = {s_r.xtal_s[0], xtal_i};
    s_nxt.sclk_d = s_r.sclk_s[1];
    s_nxt.clkout = s_r.xtal_s[1];
    s_nxt.cmd_valid = 1'b0;
    s_nxt.wr_valid = 1'b0;

    if (!cs_on) begin
      // Deselect ends any transfer at once and floats the pin
      s_nxt.phase = PH_IDLE;
      s_nxt.bit_cnt = 3'h0;
      s_nxt.drive = 1'b0;
    end else begin
      unique case (s_r.phase)
        PH_IDLE: begin
          // Select just rose; a clock already high is not an edge
          s_nxt.phase = PH_CMD;
          s_nxt.bit_cnt = 3'h0;
        end
        PH_CMD: begin
          if (sclk_rise) begin
            s_nxt.sh = in_byte;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (byte_done) begin
              s_nxt.cmd = in_byte;
              s_nxt.cmd_valid = 1'b1;
              s_nxt.first_wr = 1'b1;
              s_nxt.phase = in_byte[`RSC_RD_BIT] ? PH_RD : PH_WR;
            end
          end
        end
        PH_RD: begin
          if (sclk_fall) begin
            // Byte boundary: load the next byte, underrun sends filler
            if (byte_start) begin
              s_nxt.obyte = next_byte;
            end
            s_nxt.io_out = next_bit;
            s_nxt.drive = 1'b1;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
          end else if (sclk_rise) begin
            // Let go at once: the host may turn the line around from here
            s_nxt.drive = 1'b0;
          end
        end
        PH_WR: begin
          if (sclk_rise) begin
            s_nxt.sh = in_byte;
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (byte_done) begin
              s_nxt.wr_valid = 1'b1;
              s_nxt.wr.code = s_r.cmd;
              s_nxt.wr.data = in_byte;
              s_nxt.first_wr = 1'b0;
              if (sec_first) begin
                s_nxt.clkout_dis = in_byte[`RSC_CLKOUT_DIS_BIT];
              end
            end
          end
        end
        default: begin
          s_nxt.phase = PH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
      s_r.phase <= PH_IDLE;
      // Clock output comes back enabled long before any write can reach it
      s_r.clkout_dis <= `RSC_CLKOUT_DIS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Both enables come from flops, so neither pin can glitch on a path
  // from the synchronised inputs.
  assign io_o = s_r.io_out;
  assign io_oe_n_o = !s_r.drive;
  assign crystal_clock_output_o = s_r.clkout;
  assign crystal_clock_output_oe_n_o = s_r.clkout_dis;
  assign cmd_valid_o = s_r.cmd_valid;
  assign cmd_o.code = s_r.cmd;
  assign cmd_o.rd = s_r.cmd[`RSC_RD_BIT];
  assign wr_valid_o = s_r.wr_valid;
  assign wr_o = s_r.wr;

endmodule : rsc_serial

`default_nettype wire

// >>> rtl/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// Serial framing
`define RSC_CMD_BITS 4'h8
`define RSC_LAST_BIT 3'h7
`define RSC_RD_BIT 0
`define RSC_CLKOUT_DIS_BIT 7

// Seconds register write command (bit 0 low selects a write)
`define RSC_SEC_WR_CMD 8'h80

// Reset values
`define RSC_CLKOUT_DIS_RST 1'h0
`define RSC_UNDERRUN_BYTE 8'h00

// Read data buffer
`define RSC_FIFO_WIDTH 8
`define RSC_FIFO_DEPTH 32

`endif

// >>> rtl/rsc_pkg.sv
`default_nettype none
package rsc_pkg;

  typedef enum logic [3:0] {
    PH_IDLE = 4'b0001,
    PH_CMD = 4'b0010,
    PH_RD = 4'b0100,
    PH_WR = 4'b1000
  } rsc_phase_t;

  typedef struct packed {
    logic [7:0] code;
    logic rd;
  } rsc_cmd_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
  } rsc_wr_t;

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] sclk_s;
    logic [1:0] io_s;
    logic [1:0] xtal_s;
    logic sclk_d;
    rsc_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] obyte;
    logic drive;
    logic io_out;
    logic clkout_dis;
    logic clkout;
    logic first_wr;
    logic cmd_valid;
    logic wr_valid;
    rsc_wr_t wr;
  } rsc_state_t;

endpackage : rsc_pkg
`default_nettype wire

// >>> rtl/rsc_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module rsc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } rsc_fifo_st_t;

  rsc_fifo_st_t s_r, s_nxt;
  logic push, pop;

  assign in_ready_o = (s_r.cnt != (AW+1)'(D));
  assign out_valid_o = (s_r.cnt != '0);
  assign out_data_o = s_r.mem[s_r.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data_i;
      s_nxt.wr = (s_r.wr == AW'(D-1)) ? '0 : s_r.wr + AW'(1);
    end
    if (pop) begin
      s_nxt.rd = (s_r.rd == AW'(D-1)) ? '0 : s_r.rd + AW'(1);
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : rsc_fifo

`default_nettype wire

// >>> testbench/rsc_serial_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rsc_serial_assertions
  import rsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_i,
  input wire logic sclk_i,
  input wire logic xtal_i,
  input wire logic io_oe_n_o,
  input wire logic crystal_clock_output_o,
  input wire logic crystal_clock_output_oe_n_o,
  input wire logic cmd_valid_o,
  input wire rsc_cmd_t cmd_o,
  input wire logic wr_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Pin rises in this frame; only the command byte is judged, so wrap is harmless
  logic [3:0] n_rise_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !cs_i) begin
      n_rise_r <= 4'h0;
    end else if ($rose(sclk_i)) begin
      n_rise_r <= n_rise_r + 4'h1;
    end
  end
  a_cmd_eighth_rise: assert property (cmd_valid_o |-> n_rise_r == 4'h8)
    else $error("command not on eighth rise");
  a_wr_no_drive: assert property (!cmd_o.rd |-> io_oe_n_o)
    else $error("pin driven after a write command");
  a_idle_float: assert property (!cs_i [*6] |-> io_oe_n_o)
    else $error("pin driven while deselected");
  a_abort_float: assert property ($fell(cs_i) |-> ##[1:5] io_oe_n_o)
    else $error("pin not freed on abort");
  a_drive_on_fall: assert property ($fell(io_oe_n_o) |-> cs_i && !sclk_i)
    else $error("drive began off a falling edge");
  a_float_on_rise: assert property ($rose(sclk_i) && !io_oe_n_o |-> ##[1:5] io_oe_n_o)
    else $error("pin not freed after rise");
  a_xtal_follow: assert property (rst_n_i [*5] |-> crystal_clock_output_o == $past(xtal_i, 3))
    else $error("clock output does not follow crystal");
  a_oe_by_write: assert property ($changed(crystal_clock_output_oe_n_o)
    |-> wr_valid_o || $past(wr_valid_o) || $past(wr_valid_o, 2))
    else $error("clock enable moved without a write");
endmodule : rsc_serial_assertions
bind rsc_serial rsc_serial_assertions rsc_serial_assertions_inst (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .cs_i(cs_i), .sclk_i(sclk_i), .xtal_i(xtal_i), .io_oe_n_o(io_oe_n_o),
  .crystal_clock_output_o(crystal_clock_output_o), .cmd_valid_o(cmd_valid_o),
  .crystal_clock_output_oe_n_o(crystal_clock_output_oe_n_o), .cmd_o(cmd_o),
  .wr_valid_o(wr_valid_o));
`default_nettype wire

// >>> testbench/rsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module rsc_host_model (
  input wire logic clk_i,
  input wire logic io_i,
  output logic cs_o,
  output logic sclk_o,
  output logic io_o,
  output logic io_oe_n_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o
);
  initial begin
    cs_o = 1'b0;
    sclk_o = 1'b0;
    io_o = 1'b0;
    io_oe_n_o = 1'b1;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : wt
  // Pin is read late in the low phase: the device may float it at the rise
  task automatic bitc(input logic drv, input logic b, output logic r);
    sclk_o = 1'b0;
    io_oe_n_o = !drv;
    io_o = b;
    wt(6);
    r = io_i;
    sclk_o = 1'b1;
    wt(2);
  endtask : bitc
  task automatic xfer(input logic [7:0] cmd, input int nb, input int ny, input logic [7:0] wd);
    logic r;
    logic [7:0] sh;
    cs_o = 1'b1;
    wt(2);
    for (int i = 0; i < nb; i++) bitc(1'b1, cmd[i], r);
    for (int k = 0; k < ny; k++) begin
      for (int i = 0; i < 8; i++) begin
        bitc(!cmd[0], wd[i], r);
        sh[i] = r;
      end
      if (cmd[0]) begin
        rx_data_o = sh;
        rx_valid_o = 1'b1;
        wt(1);
        rx_valid_o = 1'b0;
      end
    end
    cs_o = 1'b0;
    wt(1);
    sclk_o = 1'b0;
    io_oe_n_o = 1'b1;
    wt(6);
  endtask : xfer
endmodule : rsc_host_model
`default_nettype wire

// >>> testbench/rtc_serial_read_and_clock_out_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module rtc_serial_read_and_clock_out_bench;
  import rsc_pkg::*;
  logic clk = 0, rst_n = 0, xtal = 0, rd_v = 0, cs, sclk, hio, hoe_n, io_o, io_oe_n, rx_v;
  logic co, co_oe_n, rd_rdy;
  logic [7:0] rd_d = 8'h00, rx_d, c, e;
  rsc_cmd_t cmd;
  rsc_wr_t wr;
  logic [7:0] q[$];
  int n_fail = 0, num_checks = 0;
  // Released line rests high on its pull-up
  wire logic io_w = !io_oe_n ? io_o : (!hoe_n ? hio : 1'b1);
  rsc_serial rsc_serial_inst (.clk_i(clk), .rst_n_i(rst_n), .cs_i(cs), .sclk_i(sclk),
    .io_i(io_w), .io_o(io_o), .io_oe_n_o(io_oe_n), .xtal_i(xtal), .crystal_clock_output_o(co),
    .crystal_clock_output_oe_n_o(co_oe_n), .rd_valid_i(rd_v), .rd_ready_o(rd_rdy),
    .rd_data_i(rd_d), .cmd_valid_o(), .cmd_o(cmd), .wr_valid_o(), .wr_o(wr));
  rsc_host_model rsc_host_model_inst (.clk_i(clk), .io_i(io_w), .cs_o(cs), .sclk_o(sclk),
    .io_o(hio), .io_oe_n_o(hoe_n), .rx_valid_o(rx_v), .rx_data_o(rx_d));
  initial forever #10 clk = ~clk;
  initial forever begin
    repeat (17) @(posedge clk);
    #2 xtal = ~xtal;
  end
  always @(posedge clk) if (rx_v) begin
    e = q.pop_front();
    `CHK(rx_d, e)
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic rst();
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #2;
  endtask : rst
  task automatic push(input logic [7:0] m = 8'h00);
    rd_d = 8'($urandom) | m;
    rd_v = 1'b1;
    q.push_back(rd_d);
    @(posedge clk);
    #2 rd_v = 1'b0;
    @(posedge clk);
    #2;
  endtask : push
  initial begin
    void'($urandom(11689));
    rst();
    `CHK(co_oe_n, 1'b0)
    `CHK(io_oe_n, 1'b1)
    while (rd_rdy === 1'b1 && q.size() < 40) push();
    `CHK(q.size(), 32)
    // Burst runs one byte past the buffer, so the underrun filler follows
    q.push_back(8'h00);
    c = 8'($urandom) | 8'h01;
    rsc_host_model_inst.xfer(c, 8, 33, 8'h00);
    `CHK(cmd, {c, 1'b1})
    `CHK(q.size(), 0)
    for (int i = 0; i < 3; i++) begin
      c = {~i[0], 7'($urandom)};
      rsc_host_model_inst.xfer(8'h80, 8, 1, c);
      `CHK(wr, {8'h80, c})
      `CHK(co_oe_n, c[7])
    end
    rst();
    `CHK(co_oe_n, 1'b0)
    // Seconds byte with a nonzero count, as the startup check expects
    push(8'h01);
    rsc_host_model_inst.xfer(8'h81, 5, 0, 8'h00);
    rsc_host_model_inst.xfer(8'h81, 8, 1, 8'h00);
    `CHK(q.size(), 0)
    `CHK(rx_d[6:0] != 7'h00, 1'b1)
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end
endmodule : rtc_serial_read_and_clock_out_bench
`default_nettype wire
